// ===== logic/pbseq_cfg.svh
// Timing and sizing constants of the push-button power sequencer.
// Assumes a single 100 MHz clock; all millisecond counts derive from it.
`ifndef PBSEQ_CFG_SVH
`define PBSEQ_CFG_SVH

`define PBSEQ_CLK_HZ 100000000
`define PBSEQ_MS_CYC(ms) (32'((ms) * (`PBSEQ_CLK_HZ / 1000)))
`define PBSEQ_QUAL_MS 20
`define PBSEQ_WARN_MS 1024
`define PBSEQ_PG_DELAY_MS 100
`define PBSEQ_WDOG_MS 10
`define PBSEQ_OC_MS 10
`define PBSEQ_HICCUP_MS 10
`define PBSEQ_NUM_CONV 3
`define PBSEQ_PERIOD_CYC 200
`define PBSEQ_CNT_W 32

`endif

// ===== logic/pbseq_pkg.sv
// Types shared by the push-button power sequencer files.
// Assumes pbseq_cfg.svh is compiled alongside.
package pbseq_pkg;
  typedef enum logic [2:0] {
    PBSEQ_SAMPLE,
    PBSEQ_AUTO_QUAL,
    PBSEQ_OFF,
    PBSEQ_ON_QUAL,
    PBSEQ_ON,
    PBSEQ_OFF_QUAL,
    PBSEQ_WARN,
    PBSEQ_HICCUP
  } pbseq_state_t;
endpackage

// ===== logic/pbseq_conv_if.sv
// Signals between the sequencer core and one converter monitor.
// Assumes one instance per converter, all on the same clock.
`timescale 1ns/1ps
interface pbseq_conv_if;
  logic global_en;
  logic en;
  logic above85;
  logic above90;
  logic overcur;
  logic run;
  logic good;
  logic oc_long;
  logic wdog_fail;
  modport ctrl
  (
    output global_en, en, above85, above90, overcur,
    input run, good, oc_long, wdog_fail
  );
  modport conv
  (
    input global_en, en, above85, above90, overcur,
    output run, good, oc_long, wdog_fail
  );
endinterface

// ===== logic/pbseq_conv.sv
// Per-converter monitor: run gating, local overload restart,
// power-good hysteresis and start-up watchdog.
// Assumes all inputs are already synchronised to clock.
`timescale 1ns/1ps
`include "pbseq_cfg.svh"
module pbseq_conv
  import pbseq_pkg::*;
#(
  parameter logic [`PBSEQ_CNT_W-1:0] OC_CYC = `PBSEQ_MS_CYC(`PBSEQ_OC_MS),
  parameter logic [`PBSEQ_CNT_W-1:0] WDOG_CYC =
    `PBSEQ_MS_CYC(`PBSEQ_WDOG_MS)
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Link to the sequencer core
  pbseq_conv_if.conv port
);
  logic [`PBSEQ_CNT_W-1:0] oc_cnt_reg, oc_cnt_next;
  logic [`PBSEQ_CNT_W-1:0] wd_cnt_reg, wd_cnt_next;
  logic run_reg, run_next;
  logic good_reg, good_next;
  logic oc_long_reg, oc_long_next;
  logic wd_fail_reg, wd_fail_next;

  // Next-state logic for one converter
  always_comb
  begin
    // Global and own enable both needed, and off while overloaded
    run_next = port.global_en & port.en & ~port.overcur;
    oc_cnt_next = oc_cnt_reg;
    oc_long_next = 1'b0;
    if (!port.overcur || !port.global_en)
    begin
      oc_cnt_next = '0; // Short overload: local restart only
    end
    else if (oc_cnt_reg != OC_CYC)
    begin
      oc_cnt_next = oc_cnt_reg + 1'b1;
      oc_long_next = (oc_cnt_reg == OC_CYC - 1'b1);
    end
    // Hysteresis between the low and high thresholds
    good_next = good_reg;
    if (!run_reg)
    begin
      good_next = 1'b0;
    end
    else if (port.above90)
    begin
      good_next = 1'b1;
    end
    else if (!port.above85)
    begin
      good_next = 1'b0;
    end
    // Start-up watchdog from the moment the converter runs
    wd_cnt_next = wd_cnt_reg;
    wd_fail_next = wd_fail_reg;
    if (!run_reg)
    begin
      wd_cnt_next = '0;
      wd_fail_next = 1'b0;
    end
    else if (!good_reg && !wd_fail_reg)
    begin
      if (wd_cnt_reg == WDOG_CYC - 1'b1)
      begin
        wd_fail_next = 1'b1;
      end
      else
      begin
        wd_cnt_next = wd_cnt_reg + 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      oc_cnt_reg <= '0;
      wd_cnt_reg <= '0;
      run_reg <= 1'b0;
      good_reg <= 1'b0;
      oc_long_reg <= 1'b0;
      wd_fail_reg <= 1'b0;
    end
    else
    begin
      oc_cnt_reg <= oc_cnt_next;
      wd_cnt_reg <= wd_cnt_next;
      run_reg <= run_next;
      good_reg <= good_next;
      oc_long_reg <= oc_long_next;
      wd_fail_reg <= wd_fail_next;
    end
  end

  assign port.run = run_reg;
  assign port.good = good_reg;
  assign port.oc_long = oc_long_reg;
  assign port.wdog_fail = wd_fail_reg;

  chk_wdog_window: assert property (@(posedge clock) disable iff (reset)
    run_reg && !good_reg && wd_cnt_reg == WDOG_CYC - 1'b1 && !wd_fail_reg
    |=> wd_fail_reg) else $error("watchdog did not flag failure");
  chk_local_off: assert property (@(posedge clock) disable iff (reset)
    port.overcur |=> !run_reg) else $error("overloaded converter ran");
endmodule

// ===== logic/pbseq_top.sv
// Push-button power sequencer: on/off detection, shutdown warning,
// power-good supervisor, hiccup restart and two-phase scheduling.
// Assumes pins are asynchronous and pass two flip-flops first.
`timescale 1ns/1ps
`include "pbseq_cfg.svh"
module pbseq_top
  import pbseq_pkg::*;
#(
  parameter int NUM_CONV = `PBSEQ_NUM_CONV,
  parameter logic [`PBSEQ_CNT_W-1:0] QUAL_CYC =
    `PBSEQ_MS_CYC(`PBSEQ_QUAL_MS),
  parameter logic [`PBSEQ_CNT_W-1:0] WARN_CYC =
    `PBSEQ_MS_CYC(`PBSEQ_WARN_MS),
  parameter logic [`PBSEQ_CNT_W-1:0] PG_DELAY_CYC =
    `PBSEQ_MS_CYC(`PBSEQ_PG_DELAY_MS),
  parameter logic [`PBSEQ_CNT_W-1:0] WDOG_CYC =
    `PBSEQ_MS_CYC(`PBSEQ_WDOG_MS),
  parameter logic [`PBSEQ_CNT_W-1:0] OC_CYC = `PBSEQ_MS_CYC(`PBSEQ_OC_MS),
  parameter logic [`PBSEQ_CNT_W-1:0] HICCUP_CYC =
    `PBSEQ_MS_CYC(`PBSEQ_HICCUP_MS),
  parameter logic [`PBSEQ_CNT_W-1:0] PERIOD_CYC = `PBSEQ_PERIOD_CYC
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Push button and regulator status pins
  input wire logic push_button_input,
  input wire logic internal_3v3_regulator_ok,
  // Per-converter pins and comparator flags
  input wire logic [NUM_CONV-1:0] converter_enable_input,
  input wire logic [NUM_CONV-1:0] vout_above_85,
  input wire logic [NUM_CONV-1:0] vout_above_90,
  input wire logic [NUM_CONV-1:0] overcurrent,
  // Converter run controls and switching turn-on pulses
  output logic [NUM_CONV-1:0] converter_run,
  output logic phase_a_turn_on,
  output logic phase_b_turn_on,
  // Open-drain shutdown warning, active low
  output logic shutdown_warn_n_o,
  output logic shutdown_warn_n_oe,
  // Open-drain power good, active high
  output logic power_good_out_o,
  output logic power_good_out_oe
);
  localparam int SYNC_W = 2 + 4 * NUM_CONV;

  logic [SYNC_W-1:0] sync1_reg, sync2_reg;
  logic pb_s, reg_ok_s;
  logic [NUM_CONV-1:0] en_s, a85_s, a90_s, oc_s;
  logic pb_last_reg, pb_last_next;
  logic pb_fall;
  pbseq_state_t state_reg, state_next;
  logic [`PBSEQ_CNT_W-1:0] cnt_reg, cnt_next;
  logic gen_reg, gen_next;
  logic warn_oe_reg, warn_oe_next;
  logic [`PBSEQ_CNT_W-1:0] pg_cnt_reg, pg_cnt_next;
  logic pg_oe_reg, pg_oe_next;
  logic [`PBSEQ_CNT_W-1:0] ph_cnt_reg, ph_cnt_next;
  logic pha_reg, pha_next, phb_reg, phb_next;
  logic [NUM_CONV-1:0] run_w, good_w, oc_long_w, wd_fail_w;
  logic all_good, any_oc_long, pb_held;

  // Two-stage synchroniser for every pin input
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= {push_button_input, internal_3v3_regulator_ok,
                    converter_enable_input, vout_above_85, vout_above_90,
                    overcurrent};
      sync2_reg <= sync1_reg;
    end
  end
  assign {pb_s, reg_ok_s, en_s, a85_s, a90_s, oc_s} = sync2_reg;

  // One monitor per converter, linked through its own interface
  generate
    for (genvar i = 0; i < NUM_CONV; i++)
    begin : g_conv
      pbseq_conv_if cif ();
      assign cif.global_en = gen_reg;
      assign cif.en = en_s[i];
      assign cif.above85 = a85_s[i];
      assign cif.above90 = a90_s[i];
      assign cif.overcur = oc_s[i];
      assign run_w[i] = cif.run;
      assign good_w[i] = cif.good;
      assign oc_long_w[i] = cif.oc_long;
      assign wd_fail_w[i] = cif.wdog_fail;
      pbseq_conv #(
        .OC_CYC(OC_CYC),
        .WDOG_CYC(WDOG_CYC)
      ) u_conv (
        .clock(clock),
        .reset(reset),
        .port(cif.conv)
      );
    end
  endgenerate

  // A falling edge is only seen after the button was high, so a tied-low
  // button never retriggers a power-on after shutdown
  assign pb_fall = pb_last_reg & ~pb_s;
  assign pb_held = ~pb_s;
  assign any_oc_long = |oc_long_w;
  assign all_good = gen_reg & (&good_w) & ~(|wd_fail_w);

  // Sequencer state machine with one shared interval counter
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg + 1'b1;
    gen_next = gen_reg;
    warn_oe_next = warn_oe_reg;
    pb_last_next = pb_s;
    case (state_reg)
      PBSEQ_SAMPLE:
      begin
        cnt_next = '0;
        gen_next = 1'b0;
        warn_oe_next = 1'b0;
        if (reg_ok_s)
        begin
          // Tied low means automatic start, high means button mode
          state_next = pb_s ? PBSEQ_OFF : PBSEQ_AUTO_QUAL;
        end
      end
      PBSEQ_AUTO_QUAL:
      begin
        if (!pb_held)
        begin
          state_next = PBSEQ_OFF; // Low broken: wait for a press
          cnt_next = '0;
        end
        else if (cnt_reg == QUAL_CYC - 1'b1)
        begin
          state_next = PBSEQ_ON;
          gen_next = 1'b1;
          cnt_next = '0;
        end
      end
      PBSEQ_OFF:
      begin
        cnt_next = '0;
        gen_next = 1'b0;
        warn_oe_next = 1'b0;
        if (pb_fall)
        begin
          state_next = PBSEQ_ON_QUAL;
        end
      end
      PBSEQ_ON_QUAL:
      begin
        if (!pb_held)
        begin
          state_next = PBSEQ_OFF; // Short press ignored
          cnt_next = '0;
        end
        else if (cnt_reg == QUAL_CYC - 1'b1)
        begin
          state_next = PBSEQ_ON;
          gen_next = 1'b1;
          cnt_next = '0;
        end
      end
      PBSEQ_ON:
      begin
        cnt_next = '0;
        if (any_oc_long)
        begin
          state_next = PBSEQ_HICCUP;
          gen_next = 1'b0;
        end
        else if (pb_fall)
        begin
          state_next = PBSEQ_OFF_QUAL;
        end
      end
      PBSEQ_OFF_QUAL:
      begin
        if (!pb_held)
        begin
          state_next = PBSEQ_ON; // Short press ignored
          cnt_next = '0;
        end
        else if (cnt_reg == QUAL_CYC - 1'b1)
        begin
          state_next = PBSEQ_WARN;
          warn_oe_next = 1'b1; // Warning pulled low
          cnt_next = '0;
        end
      end
      PBSEQ_WARN:
      begin
        // Outputs stay up while the host finishes housekeeping
        if (cnt_reg == WARN_CYC - 1'b1)
        begin
          state_next = PBSEQ_OFF;
          gen_next = 1'b0;
          warn_oe_next = 1'b0;
          cnt_next = '0;
        end
      end
      PBSEQ_HICCUP:
      begin
        // All converters held off, then start-up is tried again
        if (cnt_reg == HICCUP_CYC - 1'b1)
        begin
          state_next = PBSEQ_ON;
          gen_next = 1'b1;
          cnt_next = '0;
        end
      end
      default:
      begin
        state_next = PBSEQ_SAMPLE;
        cnt_next = '0;
      end
    endcase
    // Loss of the regulator is a power recycle and overrides all
    if (!reg_ok_s)
    begin
      state_next = PBSEQ_SAMPLE;
      gen_next = 1'b0;
      warn_oe_next = 1'b0;
      cnt_next = '0;
    end
  end

  // Sequencer registers
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= PBSEQ_SAMPLE;
      cnt_reg <= '0;
      gen_reg <= 1'b0;
      warn_oe_reg <= 1'b0;
      pb_last_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      gen_reg <= gen_next;
      warn_oe_reg <= warn_oe_next;
      pb_last_reg <= pb_last_next;
    end
  end

  // Power good: drop at once, release after the reset delay
  always_comb
  begin
    pg_cnt_next = '0;
    pg_oe_next = 1'b1;
    if (all_good)
    begin
      pg_cnt_next = pg_cnt_reg;
      pg_oe_next = pg_oe_reg;
      if (pg_cnt_reg == PG_DELAY_CYC - 1'b1)
      begin
        pg_oe_next = 1'b0;
      end
      else
      begin
        pg_cnt_next = pg_cnt_reg + 1'b1;
      end
    end
  end

  // Phase scheduler: B fires half a period after A
  always_comb
  begin
    ph_cnt_next = (ph_cnt_reg == PERIOD_CYC - 1'b1) ? '0 : ph_cnt_reg + 1'b1;
    pha_next = run_w[0] && ph_cnt_reg == '0;
    phb_next = run_w[1] && ph_cnt_reg == (PERIOD_CYC >> 1);
  end

  // Supervisor and phase registers
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pg_cnt_reg <= '0;
      pg_oe_reg <= 1'b1;
      ph_cnt_reg <= '0;
      pha_reg <= 1'b0;
      phb_reg <= 1'b0;
    end
    else
    begin
      pg_cnt_reg <= pg_cnt_next;
      pg_oe_reg <= pg_oe_next;
      ph_cnt_reg <= ph_cnt_next;
      pha_reg <= pha_next;
      phb_reg <= phb_next;
    end
  end

  // Open-drain pins only ever pull low
  assign converter_run = run_w;
  assign phase_a_turn_on = pha_reg;
  assign phase_b_turn_on = phb_reg;
  assign shutdown_warn_n_o = 1'b0;
  assign shutdown_warn_n_oe = warn_oe_reg;
  assign power_good_out_o = 1'b0;
  assign power_good_out_oe = pg_oe_reg;

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  chk_mode_sample: assert property (state_reg == PBSEQ_SAMPLE && reg_ok_s
    |=> state_reg == ($past(pb_s) ? PBSEQ_OFF : PBSEQ_AUTO_QUAL))
    else $error("wrong mode after sampling");
  chk_auto_start: assert property (state_reg == PBSEQ_AUTO_QUAL && reg_ok_s
    && !pb_s && cnt_reg == QUAL_CYC - 1'b1 |=> gen_reg)
    else $error("auto start missed");
  chk_off_holds: assert property (state_reg == PBSEQ_OFF && !pb_fall
    && reg_ok_s |=> state_reg == PBSEQ_OFF && !gen_reg)
    else $error("left off state without press");
  // Run is registered from the enable one cycle earlier
  chk_conv_enable: assert property ((run_w & ~$past(en_s)) == '0)
    else $error("converter ran without its enable");
  chk_press_on: assert property (state_reg == PBSEQ_ON_QUAL && reg_ok_s
    && !pb_s && cnt_reg == QUAL_CYC - 1'b1 |=> gen_reg)
    else $error("qualified press did not power on");
  chk_warn_drive: assert property (state_reg == PBSEQ_OFF_QUAL && reg_ok_s
    && !pb_s && cnt_reg == QUAL_CYC - 1'b1 |=> warn_oe_reg && gen_reg)
    else $error("warning not driven");
  chk_warn_off: assert property (state_reg == PBSEQ_WARN && reg_ok_s
    && cnt_reg == WARN_CYC - 1'b1 |=> !gen_reg ##1 run_w == '0)
    else $error("outputs not off after warning");
  chk_stay_off: assert property (state_reg == PBSEQ_OFF && !pb_fall
    |=> !gen_reg) else $error("powered on without edge");
  chk_pg_drop: assert property (!all_good |=> pg_oe_reg)
    else $error("power good not pulled low");
  chk_pg_delay: assert property ($fell(pg_oe_reg) |->
    $past(all_good) && $past(pg_cnt_reg) == PG_DELAY_CYC - 1'b1)
    else $error("power good released early");
  chk_hiccup_go: assert property (state_reg == PBSEQ_ON && any_oc_long
    && reg_ok_s |=> state_reg == PBSEQ_HICCUP ##1 !gen_reg)
    else $error("no hiccup on long overcurrent");
  chk_hiccup_retry: assert property (state_reg == PBSEQ_HICCUP && reg_ok_s
    && cnt_reg == HICCUP_CYC - 1'b1 |=> state_reg == PBSEQ_ON && gen_reg)
    else $error("hiccup did not restart");
  chk_phase_apart: assert property (!(pha_reg && phb_reg))
    else $error("turn-on events coincide");
  chk_short_press: assert property (state_reg == PBSEQ_ON_QUAL && pb_s
    && reg_ok_s |=> state_reg == PBSEQ_OFF)
    else $error("short press not ignored");

  cov_power_on: cover property (state_reg == PBSEQ_ON_QUAL
    ##1 state_reg == PBSEQ_ON);
  cov_shutdown: cover property (state_reg == PBSEQ_WARN
    ##1 state_reg == PBSEQ_OFF);
  cov_hiccup: cover property (state_reg == PBSEQ_HICCUP
    ##1 state_reg == PBSEQ_ON);
  cov_pg_up: cover property ($fell(pg_oe_reg));
endmodule

// ===== bench/pbseq_button_host.sv
// Model of the push button and the host on the far side of the sequencer.
// Assumes the bench clock; pull-ups stand on both open-drain pins.
`timescale 1ns/1ps
module pbseq_button_host
(
  // Clock
  input wire logic clock,
  // Button pin, low while pressed
  output logic push_button_input,
  // Open-drain pins from the sequencer
  input wire logic shutdown_warn_n_o,
  input wire logic shutdown_warn_n_oe,
  input wire logic power_good_out_o,
  input wire logic power_good_out_oe,
  // Pin levels as the host reads them
  output logic warn_pin,
  output logic pg_pin
);
  // Released pins float up to the pull-up, never hold the last level
  assign warn_pin = shutdown_warn_n_oe ? shutdown_warn_n_o : 1'b1;
  assign pg_pin = power_good_out_oe ? power_good_out_o : 1'b1;

  initial push_button_input = 1'b1;

  // Press held for n edges; called just after an edge, released likewise
  task automatic press(input int n);
    push_button_input = 1'b0;
    repeat (n) @(posedge clock);
    #1 push_button_input = 1'b1;
  endtask

  // Strap level for automatic start or idle button
  task automatic tie(input logic level);
    push_button_input = level;
  endtask
endmodule

// ===== bench/tb_pushbutton_power_sequencer.sv
// Self-checking bench for the push-button power sequencer.
// Assumes shortened counts; the host model drives the button pin.
`timescale 1ns/1ps
module tb_pushbutton_power_sequencer;
  import pbseq_pkg::*;
  localparam int QUAL = 32'h8;
  localparam int WARN = 32'h14;
  localparam int PGD = 32'hA;
  localparam int WDOG = 32'hC;
  localparam int OCC = 32'h6;
  localparam int HIC = 32'h6;
  localparam int PER = 32'h8;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic reg_ok = 1'b0;
  logic [2:0] en = 3'h7;
  logic [2:0] a85 = 3'h0;
  logic [2:0] a90 = 3'h0;
  logic [2:0] oc = 3'h0;
  logic [2:0] run;
  logic pha, phb, w_o, w_oe, p_o, p_oe, pb, warn_pin, pg_pin;
  int n_mismatch = 0;
  int samples_checked = 0;
  int model_on = 0;
  int t, k;

  always #5 clock = ~clock;

  pbseq_top #(.NUM_CONV(3), .QUAL_CYC(QUAL), .WARN_CYC(WARN),
    .PG_DELAY_CYC(PGD), .WDOG_CYC(WDOG), .OC_CYC(OCC),
    .HICCUP_CYC(HIC), .PERIOD_CYC(PER)) pbseq_top_i (
    .clock(clock), .reset(reset), .push_button_input(pb),
    .internal_3v3_regulator_ok(reg_ok), .converter_enable_input(en),
    .vout_above_85(a85), .vout_above_90(a90), .overcurrent(oc),
    .converter_run(run), .phase_a_turn_on(pha), .phase_b_turn_on(phb),
    .shutdown_warn_n_o(w_o), .shutdown_warn_n_oe(w_oe),
    .power_good_out_o(p_o), .power_good_out_oe(p_oe));

  pbseq_button_host pbseq_button_host_i (
    .clock(clock), .push_button_input(pb), .shutdown_warn_n_o(w_o),
    .shutdown_warn_n_oe(w_oe), .power_good_out_o(p_o),
    .power_good_out_oe(p_oe), .warn_pin(warn_pin), .pg_pin(pg_pin));

  // Reference: converters run when on, enabled and free of overload
  function automatic logic [2:0] exp_run();
    return (model_on != 0) ? (en & ~oc) : 3'h0;
  endfunction

  function automatic logic [2:0] cur(input int which);
    case (which)
      0: return run;
      1: return {2'h0, p_oe};
      2: return {2'h0, w_oe};
      3: return {2'h0, pha};
      default: return {2'h0, phb};
    endcase
  endfunction

  // Inputs move 1 ns after the edge so no race with the design's flops
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Bounded wait; o counts the edges it took
  task automatic wait_for(input int which, input logic [2:0] want,
    input int lim, output int o);
    o = 0;
    while (cur(which) !== want && o < lim)
    begin
      step(1);
      o++;
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (32'h4E20) @(posedge clock);
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    void'($urandom(32'hB3E3));
    step(6);
    reset = 1'b0;
    check(run, 3'h0);
    check(p_oe, 1'b1);
    check(w_oe, 1'b0);
    // Strapped low button: automatic start after qualification
    pbseq_button_host_i.tie(1'b0);
    step(2);
    reg_ok = 1'b1;
    step(QUAL);
    check(run, 3'h0);
    model_on = 1;
    wait_for(0, 3'h7, 10, t);
    check(run, exp_run());
    // Outputs reach regulation quickly, well inside the watchdog
    a85 = 3'h7;
    a90 = 3'h7;
    wait_for(1, 3'h0, PGD + 6, t);
    check(p_oe, 1'b0);
    check(t >= PGD, 1'b1);
    check(pg_pin, 1'b1);
    // Between thresholds power good holds; below the low one it drops
    a90[1] = 1'b0;
    step(8);
    check(p_oe, 1'b0);
    a85[1] = 1'b0;
    wait_for(1, 3'h1, 6, t);
    check(p_oe, 1'b1);
    a85 = 3'h7;
    a90 = 3'h7;
    wait_for(1, 3'h0, PGD + 6, t);
    check(t >= PGD, 1'b1);
    // Converter 1 turn-on lands half a period after converter 0
    wait_for(3, 3'h1, PER + 2, t);
    check(phb, 1'b0);
    step(1);
    wait_for(4, 3'h1, PER, k);
    check(k + 1, PER / 2);
    // Short overload restarts only the converter concerned
    oc = 3'h4;
    wait_for(0, 3'h3, 5, t);
    check(run, exp_run());
    oc = 3'h0;
    wait_for(0, 3'h7, 6, t);
    check(run, exp_run());
    // Sustained overload: global stop for the hiccup time, then again
    oc = 3'h1;
    wait_for(0, 3'h0, OCC + 8, t);
    check(run, 3'h0);
    wait_for(0, 3'h6, HIC + 6, k);
    check(k, HIC);
    wait_for(0, 3'h0, OCC + 8, t);
    check(run, 3'h0);
    oc = 3'h0;
    wait_for(0, 3'h7, HIC + 12, t);
    check(run, exp_run());
    // Button mode: idle high at sampling keeps everything off
    model_on = 0;
    reg_ok = 1'b0;
    pbseq_button_host_i.tie(1'b1);
    step(4);
    reg_ok = 1'b1;
    step(QUAL * 3);
    check(run, exp_run());
    pbseq_button_host_i.press($urandom_range(QUAL - 4, 1));
    step(QUAL * 2);
    check(run, exp_run());
    // Random enable mask; converter 1 reaches regulation only after the watchdog time
    en = {1'($urandom), 2'h3};
    a90 = 3'h5;
    pbseq_button_host_i.press(QUAL + 4);
    model_on = 1;
    wait_for(0, en, 8, t);
    check(run, exp_run());
    en = 3'h7;
    step(WDOG + 6);
    a90 = 3'h7;
    step(PGD + 8);
    check(p_oe, 1'b1);
    // Off press: warning first, shutdown a fixed time later
    fork
      pbseq_button_host_i.press(QUAL + 6);
    join_none
    step(QUAL - 1);
    check(w_oe, 1'b0);
    wait_for(2, 3'h1, 8, t);
    check(warn_pin, 1'b0);
    check(run, exp_run());
    wait_for(0, 3'h0, WARN + 4, k);
    check(k, WARN + 1);
    check(w_oe, 1'b0);
    model_on = 0;
    step(QUAL * 4);
    check(run, exp_run());
    pbseq_button_host_i.press(QUAL + 4);
    model_on = 1;
    wait_for(0, 3'h7, 8, t);
    check(run, exp_run());
    complete_run();
  end
endmodule
